// ==== bench/aor_reg_bank_properties.sv ====
// Checker for the register bank: write masks, reserved reads, soft reset.
// Assumes it is bound to aor_reg_bank and sees only that module's ports.
`include "aor_regs.svh"
module aor_reg_bank_properties #(
  parameter int unsigned RST_DELAY_CYC = 450
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input aor_pkg::aor_bus_req_type bus_req_in,
  input wire logic [7:0] rdata_out,
  input aor_pkg::aor_en0_type en0_out,
  input aor_pkg::aor_en1_type en1_out,
  input wire logic core_rst_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import aor_pkg::*;
  localparam int RST_LO = RST_DELAY_CYC;
  localparam int RST_HI = RST_DELAY_CYC + 4;
  logic pend_r;
  logic go;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  // Accepted command only; the bank takes a new one again in its restore cycle
  assign go = bus_req_in.wr && bus_req_in.addr == `AOR_OFS_RST_CMD &&
              bus_req_in.wdata == `AOR_RST_CODE && (!pend_r || core_rst_out);
  // Pending from the command up to the restore pulse
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) pend_r <= 1'b0;
    else if (go) pend_r <= 1'b1;
    else if (core_rst_out) pend_r <= 1'b0;
  end
  sequence s_cmd;
    go;
  endsequence
  sequence s_restore;
    ##[RST_LO:RST_HI] core_rst_out;
  endsequence
  property p_en0_wr;
    bus_req_in.wr && bus_req_in.addr == `AOR_OFS_IRQ_EN0 && !pend_r
      |=> en0_out == ($past(bus_req_in.wdata) & 8'hf7);
  endproperty
  a_en0_wr: assert property (p_en0_wr) else $error("group0 enable write wrong");
  property p_en1_wr;
    bus_req_in.wr && bus_req_in.addr == `AOR_OFS_IRQ_EN1 && !pend_r
      |=> en1_out == ($past(bus_req_in.wdata) & 8'h7f);
  endproperty
  a_en1_wr: assert property (p_en1_wr) else $error("group1 enable write wrong");
  property p_en_rd;
    bus_req_in.rd && bus_req_in.addr == `AOR_OFS_IRQ_EN0 |=> rdata_out == $past(en0_out);
  endproperty
  a_en_rd: assert property (p_en_rd) else $error("group0 read back wrong");
  property p_rsvd_rd;
    bus_req_in.rd && bus_req_in.addr == `AOR_OFS_RSVD |=> rdata_out == 8'h00;
  endproperty
  a_rsvd_rd: assert property (p_rsvd_rd) else $error("reserved offset read nonzero");
  property p_wo_rd;
    bus_req_in.rd && bus_req_in.addr == `AOR_OFS_RST_CMD |=> rdata_out == 8'h00;
  endproperty
  a_wo_rd: assert property (p_wo_rd) else $error("reset command read nonzero");
  property p_rst_time;
    s_cmd |-> s_restore;
  endproperty
  a_rst_time: assert property (p_rst_time) else $error("restore pulse late");
  property p_rst_quiet;
    s_cmd |=> !core_rst_out [*4];
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("restore pulse early");
  property p_rst_cause;
    core_rst_out |-> pend_r;
  endproperty
  a_rst_cause: assert property (p_rst_cause) else $error("restore without command");
  property p_restore;
    core_rst_out |-> ##[0:1] (en0_out == 8'h00 && en1_out == 8'h00) ##1 !core_rst_out;
  endproperty
  a_restore: assert property (p_restore) else $error("enables not restored");
endmodule

bind aor_reg_bank aor_reg_bank_properties #(.RST_DELAY_CYC(RST_DELAY_CYC)) u_props (
  .sys_clk_in, .srst_in, .bus_req_in, .rdata_out, .en0_out, .en1_out, .core_rst_out);

// ==== bench/aor_reg_bank_tb_top.sv ====
// Self-checking bench: registers, output select, shadow lock, soft reset, irq.
// Assumes aor_pkg and the design are compiled before this file.
`include "aor_regs.svh"
module aor_reg_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import aor_pkg::*;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  aor_bus_req_type req = '0;
  logic vld = 1'b0;
  aor_axis_type filt [3] = '{default: '0};
  aor_axis_type raw [3] = '{default: '0};
  logic [7:0] rdata;
  aor_en0_type en0;
  aor_en1_type en1;
  logic core_rst;
  logic irq;
  int failures = 0;
  int checks = 0;
  always #2 sys_clk_in = ~sys_clk_in;
  // Short settle count keeps the reset wait brief
  aor_reg_bank #(.RST_DELAY_CYC(4)) DUT (
    .sys_clk_in, .srst_in, .bus_req_in(req), .rdata_out(rdata), .sample_vld_in(vld),
    .filt_x_in(filt[0]), .filt_y_in(filt[1]), .filt_z_in(filt[2]),
    .raw_x_in(raw[0]), .raw_y_in(raw[1]), .raw_z_in(raw[2]),
    .en0_out(en0), .en1_out(en1), .core_rst_out(core_rst), .irq_out(irq));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk_in);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge sys_clk_in);
    req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk_in);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge sys_clk_in);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Filtered lsb 01..03, raw lsb 81..83; msb carries k or its inverse
  task automatic smp(input logic [7:0] k);
    @(posedge sys_clk_in);
    for (int i = 0; i < 3; i++) begin
      filt[i] <= {k, 8'h01 + 8'(i)};
      raw[i] <= {~k, 8'h81 + 8'(i)};
    end
    vld <= 1'b1;
    @(posedge sys_clk_in);
    vld <= 1'b0;
    #1;
  endtask
  task automatic t_regs();
    logic [7:0] v;
    wr(`AOR_OFS_RST_CMD, 8'h55);
    wr(`AOR_OFS_RSVD, 8'hff);
    wr(8'h18, 8'hff);
    for (int i = 0; i < 6; i++) begin
      rd(8'h13 + 8'(i), v);
      chk("reset or empty reg", v, 8'h00);
    end
    for (int b = 0; b < 8; b++) begin
      wr(`AOR_OFS_IRQ_EN0, 8'h01 << b);
      chk("en0", en0, (8'h01 << b) & 8'hf7);
      wr(`AOR_OFS_IRQ_EN1, 8'h01 << b);
      chk("en1", en1, (8'h01 << b) & 8'h7f);
    end
    rd(`AOR_OFS_IRQ_EN0, v);
    chk("en0 read", v, 8'h80);
    wr(`AOR_OFS_OUT_CFG, 8'hff);
    rd(`AOR_OFS_OUT_CFG, v);
    chk("cfg read", v, 8'hc0);
  endtask
  // Both selections, every axis, low then high byte
  task automatic t_sel();
    logic [7:0] v;
    for (int s = 0; s < 2; s++) begin
      wr(`AOR_OFS_OUT_CFG, s ? 8'h80 : 8'h00);
      smp(8'h5a);
      for (int i = 0; i < 3; i++) begin
        rd(8'h02 + 8'(2 * i), v);
        chk("lsb", v, (s ? 8'h81 : 8'h01) + 8'(i));
        rd(8'h03 + 8'(2 * i), v);
        chk("msb", v, s ? 8'ha5 : 8'h5a);
      end
    end
  endtask
  task automatic t_shadow();
    logic [7:0] v;
    wr(`AOR_OFS_OUT_CFG, 8'h00);
    smp(8'h11);
    rd(`AOR_OFS_DATA_Y_LSB, v);
    smp(8'h22);
    rd(`AOR_OFS_DATA_Y_MSB, v);
    chk("locked msb", v, 8'h11);
    smp(8'h33);
    rd(`AOR_OFS_DATA_Y_MSB, v);
    chk("released msb", v, 8'h33);
    wr(`AOR_OFS_OUT_CFG, 8'h40);
    rd(`AOR_OFS_DATA_Y_LSB, v);
    smp(8'h44);
    rd(`AOR_OFS_DATA_Y_MSB, v);
    chk("unlocked msb", v, 8'h44);
  endtask
  task automatic t_reset();
    logic [7:0] v;
    int n;
    wr(`AOR_OFS_IRQ_EN0, 8'hff);
    wr(`AOR_OFS_RST_CMD, `AOR_RST_CODE);
    wr(`AOR_OFS_IRQ_EN0, 8'h00);
    chk("write while pending", en0, 8'hf7);
    n = 0;
    while (core_rst !== 1'b1 && n < 40) begin
      @(posedge sys_clk_in);
      #1 n++;
    end
    chk("restore pulse", {7'h00, core_rst}, 8'h01);
    @(posedge sys_clk_in);
    #1 chk("en0 default", en0, 8'h00);
    rd(`AOR_OFS_OUT_CFG, v);
    chk("cfg stored", v, 8'h00);
    wr(`AOR_OFS_IRQ_EN0, 8'h30); // Reserved bits left zero
    chk("en0 rewritten", en0, 8'h30);
  endtask
  // Reset-done pending from t_reset; sample bit cleared first, then raised
  task automatic chk_irq(input logic exp);
    repeat (2) @(posedge sys_clk_in);
    #1 chk("irq", {7'h00, irq}, {7'h00, exp});
  endtask
  task automatic t_irq();
    logic [7:0] v;
    chk_irq(1'b0);
    wr(`AOR_OFS_EVT_MASK, 8'h01);
    chk_irq(1'b1);
    wr(`AOR_OFS_EVT_STAT, 8'h03);
    chk_irq(1'b0);
    wr(`AOR_OFS_EVT_MASK, 8'h02);
    chk_irq(1'b0);
    smp(8'h66);
    chk_irq(1'b1);
    rd(`AOR_OFS_EVT_STAT, v);
    chk("event status", v, 8'h02);
    wr(`AOR_OFS_EVT_STAT, 8'h02);
    chk_irq(1'b0);
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    t_regs();
    $display("test regs done");
    t_sel();
    $display("test select done");
    t_shadow();
    $display("test shadow done");
    t_reset();
    $display("test reset done");
    t_irq();
    $display("test irq done");
    print_verdict();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    failures++;
    print_verdict();
  end
endmodule

// ==== hdl/aor_axis_latch.sv ====
// One axis output pair with high-byte shadow lock.
// Assumes sample and read strobes come from the same clock domain.
module aor_axis_latch (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic sample_vld_in,
  input aor_pkg::aor_axis_type sample_in,
  input wire logic shadow_dis_in,
  input wire logic lsb_rd_in,
  input wire logic msb_rd_in,
  output aor_pkg::aor_axis_type data_out
);
  import aor_pkg::*;

  typedef struct packed {
    aor_axis_type data;
    logic locked;
  } aor_axis_state_type;

  aor_axis_state_type state_r;
  aor_axis_state_type state_nxt;

  // Low byte always follows samples; high byte held while locked
  always_comb begin
    state_nxt = state_r;
    if (sample_vld_in) begin
      state_nxt.data.lsb = sample_in.lsb;
      // A sample landing with the low-byte read must not split the pair
      if ((!state_r.locked && !lsb_rd_in) || shadow_dis_in) begin
        state_nxt.data.msb = sample_in.msb;
      end
    end
    if (msb_rd_in || shadow_dis_in) begin
      state_nxt.locked = 1'b0;
    end else if (lsb_rd_in) begin
      state_nxt.locked = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign data_out = state_r.data;
endmodule

// ==== hdl/aor_reg_bank.sv ====
// Accelerometer register bank: output select, shadow lock, soft reset,
// interrupt engine enables, plus an event status/mask pair for one irq line.
// Assumes the sensor core supplies filtered and unfiltered samples on
// this clock and keeps engines off while their enable bit is clear.
//
// Operation
// - Bit 7 of the output config register picks unfiltered samples when set, filtered when clear.
// - With bit 6 clear, reading an axis low byte freezes that axis high byte; bit 6 set disables it.
// - Reading the frozen high byte releases the lock so new samples update it.
// - Writing 0xb6 to the reset command register starts a soft reset; other values do nothing.
// - After a settle delay the soft reset restores every setting to default or its stored value.
// - The reset command works in every power mode, suspend and low power included.
// - Offset 0x15 is reserved, reads zero and ignores writes.
// - Group 0 bits 7 to 4 enable flat, orientation, single tap and double tap, active high.
// - Group 0 bits 2 to 0 enable slope detection on z, y and x.
// - Group 1 bits 6 to 3 enable FIFO watermark, FIFO full, data ready and low-g.
// - Group 1 bits 2 to 0 enable high-g detection on z, y and x.
//
// The plain strobed port was decided locally.
`include "aor_regs.svh"

module aor_reg_bank #(
  parameter int unsigned RST_DELAY_CYC = `AOR_RST_DELAY_CYC,
  parameter logic [7:0] NVM_OUT_CFG = `AOR_RST_OUT_CFG
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input aor_pkg::aor_bus_req_type bus_req_in,
  output logic [7:0] rdata_out,
  input wire logic sample_vld_in,
  input aor_pkg::aor_axis_type filt_x_in,
  input aor_pkg::aor_axis_type filt_y_in,
  input aor_pkg::aor_axis_type filt_z_in,
  input aor_pkg::aor_axis_type raw_x_in,
  input aor_pkg::aor_axis_type raw_y_in,
  input aor_pkg::aor_axis_type raw_z_in,
  output aor_pkg::aor_en0_type en0_out,
  output aor_pkg::aor_en1_type en1_out,
  output logic core_rst_out,
  output logic irq_out
);
  import aor_pkg::*;

  localparam int unsigned CW = $clog2(RST_DELAY_CYC + 1);

  typedef struct packed {
    logic [7:0] out_cfg;
    aor_en0_type en0;
    aor_en1_type en1;
    logic [1:0] evt_stat;
    logic [1:0] evt_mask;
    aor_rst_state_type rst_state;
    logic [CW-1:0] rst_cnt;
    logic [7:0] rdata;
    logic core_rst;
    logic irq;
  } aor_bank_state_type;

  aor_bank_state_type state_r;
  aor_bank_state_type state_nxt;

  aor_axis_type sel_x;
  aor_axis_type sel_y;
  aor_axis_type sel_z;
  aor_axis_type data_x;
  aor_axis_type data_y;
  aor_axis_type data_z;
  logic wr_cfg;
  logic [1:0] evt_set;

  // Output source select sits ahead of the shadow latches
  assign sel_x = state_r.out_cfg[`AOR_BIT_UNFILT_SEL] ? raw_x_in : filt_x_in;
  assign sel_y = state_r.out_cfg[`AOR_BIT_UNFILT_SEL] ? raw_y_in : filt_y_in;
  assign sel_z = state_r.out_cfg[`AOR_BIT_UNFILT_SEL] ? raw_z_in : filt_z_in;

  aor_axis_latch u_axis_x (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .sample_vld_in(sample_vld_in),
    .sample_in(sel_x),
    .shadow_dis_in(state_r.out_cfg[`AOR_BIT_SHADOW_DIS]),
    .lsb_rd_in(bus_req_in.rd && bus_req_in.addr == `AOR_OFS_DATA_X_LSB),
    .msb_rd_in(bus_req_in.rd && bus_req_in.addr == `AOR_OFS_DATA_X_MSB),
    .data_out(data_x)
  );

  aor_axis_latch u_axis_y (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .sample_vld_in(sample_vld_in),
    .sample_in(sel_y),
    .shadow_dis_in(state_r.out_cfg[`AOR_BIT_SHADOW_DIS]),
    .lsb_rd_in(bus_req_in.rd && bus_req_in.addr == `AOR_OFS_DATA_Y_LSB),
    .msb_rd_in(bus_req_in.rd && bus_req_in.addr == `AOR_OFS_DATA_Y_MSB),
    .data_out(data_y)
  );

  aor_axis_latch u_axis_z (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .sample_vld_in(sample_vld_in),
    .sample_in(sel_z),
    .shadow_dis_in(state_r.out_cfg[`AOR_BIT_SHADOW_DIS]),
    .lsb_rd_in(bus_req_in.rd && bus_req_in.addr == `AOR_OFS_DATA_Z_LSB),
    .msb_rd_in(bus_req_in.rd && bus_req_in.addr == `AOR_OFS_DATA_Z_MSB),
    .data_out(data_z)
  );

  // Config writes are blocked while a soft reset is pending
  assign wr_cfg = bus_req_in.wr && state_r.rst_state == AOR_RUN;

  // All next-state logic of the bank
  always_comb begin
    state_nxt = state_r;
    evt_set = 2'h0;
    state_nxt.core_rst = 1'b0;
    if (wr_cfg) begin
      case (bus_req_in.addr)
        `AOR_OFS_OUT_CFG: begin
          state_nxt.out_cfg = bus_req_in.wdata & `AOR_OUT_CFG_WMASK;
        end
        `AOR_OFS_IRQ_EN0: begin
          state_nxt.en0 = bus_req_in.wdata & `AOR_EN0_WMASK;
        end
        `AOR_OFS_IRQ_EN1: begin
          state_nxt.en1 = bus_req_in.wdata & `AOR_EN1_WMASK;
        end
        `AOR_OFS_EVT_MASK: begin
          state_nxt.evt_mask = bus_req_in.wdata[1:0];
        end
        default: begin
          // Reserved 0x15 and unmapped offsets ignore writes
        end
      endcase
    end
    // Soft reset sequencer; no power-mode gating so it runs in any mode
    case (state_r.rst_state)
      AOR_RUN: begin
        if (bus_req_in.wr && bus_req_in.addr == `AOR_OFS_RST_CMD &&
            bus_req_in.wdata == `AOR_RST_CODE) begin
          state_nxt.rst_state = AOR_RST_WAIT;
          state_nxt.rst_cnt = CW'(RST_DELAY_CYC - 1);
        end
      end
      AOR_RST_WAIT: begin
        if (state_r.rst_cnt == '0) begin
          state_nxt.rst_state = AOR_RST_LOAD;
        end else begin
          state_nxt.rst_cnt = state_r.rst_cnt - 1'b1;
        end
      end
      AOR_RST_LOAD: begin
        // Restore defaults; output config comes from stored image
        state_nxt.out_cfg = NVM_OUT_CFG & `AOR_OUT_CFG_WMASK;
        state_nxt.en0 = `AOR_RST_IRQ_EN;
        state_nxt.en1 = `AOR_RST_IRQ_EN;
        state_nxt.evt_mask = 2'h0;
        state_nxt.core_rst = 1'b1;
        state_nxt.rst_state = AOR_RUN;
        evt_set[`AOR_EVT_RST_DONE] = 1'b1;
      end
      default: begin
        state_nxt.rst_state = AOR_RUN;
      end
    endcase
    evt_set[`AOR_EVT_SAMPLE] = sample_vld_in;
    // Write-one-to-clear, but a same-cycle event keeps its bit
    if (bus_req_in.wr && bus_req_in.addr == `AOR_OFS_EVT_STAT) begin
      state_nxt.evt_stat = state_r.evt_stat & ~bus_req_in.wdata[1:0];
    end
    state_nxt.evt_stat = state_nxt.evt_stat | evt_set;
    state_nxt.irq = |(state_nxt.evt_stat & state_nxt.evt_mask);
    // Read data registered, one cycle after the strobe
    state_nxt.rdata = 8'h00;
    if (bus_req_in.rd) begin
      case (bus_req_in.addr)
        `AOR_OFS_OUT_CFG: state_nxt.rdata = state_r.out_cfg;
        `AOR_OFS_IRQ_EN0: state_nxt.rdata = state_r.en0;
        `AOR_OFS_IRQ_EN1: state_nxt.rdata = state_r.en1;
        `AOR_OFS_DATA_X_LSB: state_nxt.rdata = data_x.lsb;
        `AOR_OFS_DATA_X_MSB: state_nxt.rdata = data_x.msb;
        `AOR_OFS_DATA_Y_LSB: state_nxt.rdata = data_y.lsb;
        `AOR_OFS_DATA_Y_MSB: state_nxt.rdata = data_y.msb;
        `AOR_OFS_DATA_Z_LSB: state_nxt.rdata = data_z.lsb;
        `AOR_OFS_DATA_Z_MSB: state_nxt.rdata = data_z.msb;
        `AOR_OFS_EVT_STAT: state_nxt.rdata = {6'h00, state_r.evt_stat};
        `AOR_OFS_EVT_MASK: state_nxt.rdata = {6'h00, state_r.evt_mask};
        default: state_nxt.rdata = 8'h00; // Write-only, reserved, unmapped
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      state_r <= '0;
      state_r.out_cfg <= `AOR_RST_OUT_CFG;
      state_r.rst_state <= AOR_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Enables feed the engines straight from flops
  assign en0_out = state_r.en0;
  assign en1_out = state_r.en1;
  assign rdata_out = state_r.rdata;
  assign core_rst_out = state_r.core_rst;
  assign irq_out = state_r.irq;
endmodule

// ==== include/aor_pkg.sv ====
// Types shared by the accelerometer register bank and its axis latch.
// Assumes aor_regs.svh supplies the numeric constants.
package aor_pkg;

  typedef enum logic [1:0] {
    AOR_RUN,
    AOR_RST_WAIT,
    AOR_RST_LOAD
  } aor_rst_state_type;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } aor_bus_req_type;

  // Group 0 enables, bit 7 down to bit 0
  typedef struct packed {
    logic flat;
    logic orient;
    logic s_tap;
    logic d_tap;
    logic rsvd;
    logic slope_z;
    logic slope_y;
    logic slope_x;
  } aor_en0_type;

  // Group 1 enables, bit 7 down to bit 0
  typedef struct packed {
    logic rsvd;
    logic fifo_wm;
    logic fifo_full;
    logic data_rdy;
    logic low_g;
    logic high_z;
    logic high_y;
    logic high_x;
  } aor_en1_type;

  // One axis sample
  typedef struct packed {
    logic [7:0] msb;
    logic [7:0] lsb;
  } aor_axis_type;

endpackage

// ==== include/aor_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the
// accelerometer output, soft reset and interrupt enable register bank.
// Assumes an 8-bit register port addressed by byte offset.
`ifndef AOR_REGS_SVH
`define AOR_REGS_SVH

`define AOR_OFS_OUT_CFG 8'h13
`define AOR_OFS_RST_CMD 8'h14
`define AOR_OFS_RSVD 8'h15
`define AOR_OFS_IRQ_EN0 8'h16
`define AOR_OFS_IRQ_EN1 8'h17
`define AOR_OFS_DATA_X_LSB 8'h02
`define AOR_OFS_DATA_X_MSB 8'h03
`define AOR_OFS_DATA_Y_LSB 8'h04
`define AOR_OFS_DATA_Y_MSB 8'h05
`define AOR_OFS_DATA_Z_LSB 8'h06
`define AOR_OFS_DATA_Z_MSB 8'h07
`define AOR_OFS_EVT_STAT 8'h30
`define AOR_OFS_EVT_MASK 8'h31

`define AOR_BIT_UNFILT_SEL 7
`define AOR_BIT_SHADOW_DIS 6
`define AOR_OUT_CFG_WMASK 8'hc0
`define AOR_EN0_WMASK 8'hf7
`define AOR_EN1_WMASK 8'h7f

`define AOR_RST_OUT_CFG 8'h00
`define AOR_RST_IRQ_EN 8'h00
`define AOR_RST_CODE 8'hb6

`define AOR_EVT_RST_DONE 0
`define AOR_EVT_SAMPLE 1

// Soft reset settle time and its cycle count at 250 MHz (4 ns period)
`define AOR_RST_DELAY_NS 1800
`define AOR_CLK_PERIOD_NS 4
`define AOR_RST_DELAY_CYC ((`AOR_RST_DELAY_NS + `AOR_CLK_PERIOD_NS - 1) / `AOR_CLK_PERIOD_NS)

`endif
